// ### pkg/cwu_regs.svh
// Register offsets, field positions and reset values of the complementary wave unit.
`ifndef CWU_REGS_SVH
`define CWU_REGS_SVH

// ==========================================================================
// Register byte offsets on the AHB-Lite register port.
`define CWU_OFS_CTRL0 8'h00
`define CWU_OFS_CTRL1 8'h04
`define CWU_OFS_DBR 8'h08
`define CWU_OFS_DBF 8'h0c
`define CWU_OFS_OVR 8'h10
`define CWU_OFS_STAT 8'h14

// ==========================================================================
// Field positions of wave_control_zero.
`define CWU_C0_EN 7
`define CWU_C0_OEB 6
`define CWU_C0_OEA 5
`define CWU_C0_POLB 4
`define CWU_C0_POLA 3
`define CWU_C0_CS 0

// Field positions of the override register.
`define CWU_OVR_EN 0
`define CWU_OVR_LA 1
`define CWU_OVR_LB 2

// Field positions of the status register.
`define CWU_ST_A 0
`define CWU_ST_B 1
`define CWU_ST_IN 2
`define CWU_ST_RBUSY 3
`define CWU_ST_FBUSY 4

// ==========================================================================
// Widths and reset values.
`define CWU_DB_W 6
`define CWU_IS_W 3
`define CWU_CTRL0_RST 8'h00
`define CWU_CTRL1_RST 3'h0
`define CWU_DB_RST 6'h00
`define CWU_OVR_RST 3'h0
`define CWU_ADDR_W 8

`endif

// ### pkg/cwu_pkg.sv
// Types shared by the complementary wave unit design files.
`default_nettype none

package cwu_pkg;

   // Dead-band counter state.
   typedef enum logic {CWU_DB_IDLE, CWU_DB_COUNT} cwu_db_state_t;

   // Input source selection codes.
   typedef enum logic [2:0] {
      CWU_SRC_CMP = 3'h0,
      CWU_SRC_PWM1 = 3'h1,
      CWU_SRC_PWM2 = 3'h2,
      CWU_SRC_PWM3 = 3'h3,
      CWU_SRC_PWM4 = 3'h4,
      CWU_SRC_NCO = 3'h5,
      CWU_SRC_LC = 3'h6,
      CWU_SRC_NONE = 3'h7
   } cwu_src_t;

endpackage

`default_nettype wire

// ### core/cwu_deadband.sv
// One dead-band interval counter, started by an input edge.
`include "cwu_regs.svh"
`default_nettype none

module cwu_deadband
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic abort,
   input wire logic tick,
   input wire logic [`CWU_DB_W-1:0] limit,
   output logic fire,
   output logic busy
);

   // ==========================================================================
   // State.
   cwu_pkg::cwu_db_state_t state; // Idle or counting.
   cwu_pkg::cwu_db_state_t next_state; // Next value of state.
   logic [`CWU_DB_W-1:0] count; // Generator periods elapsed.
   logic [`CWU_DB_W-1:0] next_count; // Next value of count.
   logic [`CWU_DB_W-1:0] limit_held; // Limit latched at the edge.
   logic [`CWU_DB_W-1:0] next_limit_held; // Next value of limit_held.
   logic [`CWU_DB_W-1:0] count_inc; // Count after this tick.

   assign count_inc = count + `CWU_DB_W'(1);
   assign busy = (state == cwu_pkg::CWU_DB_COUNT);

   // Count generator periods from zero up to the limit; the limit is
   // latched at the edge so a rewrite mid-interval cannot shorten it.
   always_comb
   begin
      next_state = state;
      next_count = count;
      next_limit_held = limit_held;
      fire = 1'b0;
      if (abort)
      begin
         // The input went back before the count ended: no turn-on. [R16]
         next_state = cwu_pkg::CWU_DB_IDLE;
         next_count = '0;
      end
      else if (start)
      begin
         // Counting always restarts from the input edge itself. [R15] [R10]
         next_count = '0;
         next_limit_held = limit;
         if (limit == '0)
         begin
            // A zero setting turns the output on with no delay. [R14]
            fire = 1'b1;
            next_state = cwu_pkg::CWU_DB_IDLE;
         end
         else
         begin
            next_state = cwu_pkg::CWU_DB_COUNT;
         end
      end
      else if (busy && tick)
      begin
         next_count = count_inc;
         if (count_inc == limit_held)
         begin
            // Interval done: the waiting output may turn on. [R10]
            fire = 1'b1;
            next_state = cwu_pkg::CWU_DB_IDLE;
         end
      end
   end

   // Register the counter state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= cwu_pkg::CWU_DB_IDLE;
         count <= '0;
         limit_held <= `CWU_DB_RST;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         limit_held <= next_limit_held;
      end
   end

endmodule

`default_nettype wire

// ### core/cwu_top.sv
// Complementary wave unit: AHB-Lite registers, input select and drive logic.
`include "cwu_regs.svh"
`default_nettype none

// Function
// R01 - Generator timed by system or oscillator clock.
// R02 - Select one picks oscillator, zero system.
// R03 - Three-bit field selects the single input.
// R04 - Enabling starts with both drives cleared.
// R05 - Pin enable gives the pin to module.
// R06 - Disabled unit has no influence on pins.
// R07 - Polarity bit set means active-high output.
// R08 - Polarity never applies to override levels.
// R09 - Two 6-bit counters, rising and falling edge.
// R10 - Count generator periods up to register value.
// R11 - Rising edge: B off, delay, then A on.
// R12 - Falling edge: A off, delay, then B on.
// R13 - Each edge has its own dead-band setting.
// R14 - Zero setting inserts no delay.
// R15 - Counting starts from the input edge.
// R16 - Too-short input pulse leaves output off.
// R17 - Dead-band error bounded to one period.
// R18 - Input synchronised before edge detection.
module cwu_top
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic internal_fast_oscillator,
   input wire logic comparator_out_synced,
   input wire logic pwm_one_output,
   input wire logic pwm_two_output,
   input wire logic pwm_three_output,
   input wire logic pwm_four_output,
   input wire logic numeric_osc_output,
   input wire logic logic_cell_output,
   output logic drive_out_a,
   output logic drive_out_a_oe,
   output logic drive_out_b,
   output logic drive_out_b_oe
);

   // ==========================================================================
   // Bus slave state.
   logic wr_pend; // A write data phase is under way.
   logic next_wr_pend; // Next value of wr_pend.
   logic [`CWU_ADDR_W-1:0] wr_addr; // Offset of the pending write.
   logic [`CWU_ADDR_W-1:0] next_wr_addr; // Next value of wr_addr.
   logic [31:0] next_hrdata; // Read data for the coming data phase.
   logic [7:0] ctrl0; // wave_control_zero.
   logic [7:0] next_ctrl0; // Next value of ctrl0.
   logic [`CWU_IS_W-1:0] input_select; // wave_control_one.
   logic [`CWU_IS_W-1:0] next_input_select; // Next value of input_select.
   logic [`CWU_DB_W-1:0] rise_deadband_count; // Rising-edge dead band.
   logic [`CWU_DB_W-1:0] next_rise_deadband_count; // Next rising setting.
   logic [`CWU_DB_W-1:0] fall_deadband_count; // Falling-edge dead band.
   logic [`CWU_DB_W-1:0] next_fall_deadband_count; // Next falling setting.
   logic [2:0] ovr; // Override enable and levels.
   logic [2:0] next_ovr; // Next value of ovr.
   logic addr_ok; // An address phase is accepted this cycle.
   logic [`CWU_ADDR_W-1:0] a_ofs; // Offset presented in the address phase.

   // ==========================================================================
   // Datapath state.
   logic in_meta; // First synchroniser stage.
   logic in_sync; // Second synchroniser stage.
   logic in_prev; // Synchronised input one cycle ago.
   logic osc_prev; // Oscillator level one cycle ago.
   logic en_prev; // Unit enable one cycle ago.
   logic drv_a; // Active-high internal drive A.
   logic drv_b; // Active-high internal drive B.
   logic next_drv_a; // Next value of drv_a.
   logic next_drv_b; // Next value of drv_b.
   logic next_pin_a; // Next pin level A.
   logic next_pin_b; // Next pin level B.
   logic next_oe_a; // Next pin enable A.
   logic next_oe_b; // Next pin enable B.
   logic sel_in; // Selected source before synchronising.
   logic in_rise; // Rising edge of the synchronised input.
   logic in_fall; // Falling edge of the synchronised input.
   logic gen_tick; // One generator clock period has passed.
   logic unit_enable; // Module enable bit.
   logic rise_fire; // Rising dead band ended this cycle.
   logic fall_fire; // Falling dead band ended this cycle.
   logic rise_busy; // Rising dead band is counting.
   logic fall_busy; // Falling dead band is counting.

   assign unit_enable = ctrl0[`CWU_C0_EN];
   assign a_ofs = haddr[`CWU_ADDR_W-1:0];
   assign addr_ok = hsel && hready && htrans[1];
   // Every transfer completes with no wait state and an OKAY answer.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ==========================================================================
   // Register bus.
   // The address phase is captured here; reads are answered from a flop
   // loaded at the address edge, writes land at the end of the data phase.
   always_comb
   begin
      next_wr_pend = addr_ok && hwrite;
      next_wr_addr = addr_ok ? a_ofs : wr_addr;
      next_hrdata = hrdata;
      next_ctrl0 = ctrl0;
      next_input_select = input_select;
      next_rise_deadband_count = rise_deadband_count;
      next_fall_deadband_count = fall_deadband_count;
      next_ovr = ovr;
      if (addr_ok && !hwrite)
      begin
         // Unmapped offsets and unused bits read as zero.
         next_hrdata = '0;
         unique case (a_ofs)
            `CWU_OFS_CTRL0: next_hrdata[7:0] = ctrl0;
            `CWU_OFS_CTRL1: next_hrdata[`CWU_IS_W-1:0] = input_select;
            `CWU_OFS_DBR: next_hrdata[`CWU_DB_W-1:0] = rise_deadband_count;
            `CWU_OFS_DBF: next_hrdata[`CWU_DB_W-1:0] = fall_deadband_count;
            `CWU_OFS_OVR: next_hrdata[2:0] = ovr;
            `CWU_OFS_STAT:
            begin
               next_hrdata[`CWU_ST_A] = drv_a;
               next_hrdata[`CWU_ST_B] = drv_b;
               next_hrdata[`CWU_ST_IN] = in_sync;
               next_hrdata[`CWU_ST_RBUSY] = rise_busy;
               next_hrdata[`CWU_ST_FBUSY] = fall_busy;
            end
            default: next_hrdata = '0;
         endcase
      end
      if (wr_pend)
      begin
         // Writes to unmapped or read-only offsets are dropped.
         unique case (wr_addr)
            // Bits 2 and 1 of control zero are unimplemented.
            `CWU_OFS_CTRL0: next_ctrl0 = hwdata[7:0] & 8'hf9;
            `CWU_OFS_CTRL1: next_input_select = hwdata[`CWU_IS_W-1:0]; // [R03]
            `CWU_OFS_DBR: next_rise_deadband_count = hwdata[`CWU_DB_W-1:0]; // [R13]
            `CWU_OFS_DBF: next_fall_deadband_count = hwdata[`CWU_DB_W-1:0]; // [R13]
            `CWU_OFS_OVR: next_ovr = hwdata[2:0];
            default: next_ovr = ovr;
         endcase
      end
   end

   // Register the bus-side state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         hrdata <= '0;
         ctrl0 <= `CWU_CTRL0_RST;
         input_select <= `CWU_CTRL1_RST;
         rise_deadband_count <= `CWU_DB_RST;
         fall_deadband_count <= `CWU_DB_RST;
         ovr <= `CWU_OVR_RST;
      end
      else
      begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         ctrl0 <= next_ctrl0;
         input_select <= next_input_select;
         rise_deadband_count <= next_rise_deadband_count;
         fall_deadband_count <= next_fall_deadband_count;
         ovr <= next_ovr;
      end
   end

   // ==========================================================================
   // Input selection, synchroniser and edge detection.
   // Code seven has no source and holds the input low.
   always_comb
   begin
      unique case (cwu_pkg::cwu_src_t'(input_select)) // [R03]
         cwu_pkg::CWU_SRC_CMP: sel_in = comparator_out_synced;
         cwu_pkg::CWU_SRC_PWM1: sel_in = pwm_one_output;
         cwu_pkg::CWU_SRC_PWM2: sel_in = pwm_two_output;
         cwu_pkg::CWU_SRC_PWM3: sel_in = pwm_three_output;
         cwu_pkg::CWU_SRC_PWM4: sel_in = pwm_four_output;
         cwu_pkg::CWU_SRC_NCO: sel_in = numeric_osc_output;
         cwu_pkg::CWU_SRC_LC: sel_in = logic_cell_output;
         cwu_pkg::CWU_SRC_NONE: sel_in = 1'b0;
      endcase
   end

   // Edges are taken after the second stage only, so each input edge
   // starts exactly one count even if the source is asynchronous.
   assign in_rise = in_sync && !in_prev; // [R18]
   assign in_fall = !in_sync && in_prev; // [R18]

   // With the oscillator selected a period is one oscillator rising edge,
   // otherwise every system clock. Sampling the oscillator costs at most
   // one generator period of dead-band error, never more. [R01] [R02] [R17]
   assign gen_tick = ctrl0[`CWU_C0_CS] ? (internal_fast_oscillator && !osc_prev) : 1'b1;

   // ==========================================================================
   // Dead-band counters, one per input edge.
   cwu_deadband u_rise_db // [R09]
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(in_rise && unit_enable),
      .abort(in_fall || !unit_enable),
      .tick(gen_tick),
      .limit(rise_deadband_count),
      .fire(rise_fire),
      .busy(rise_busy)
   );

   cwu_deadband u_fall_db // [R09]
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(in_fall && unit_enable),
      .abort(in_rise || !unit_enable),
      .tick(gen_tick),
      .limit(fall_deadband_count),
      .fire(fall_fire),
      .busy(fall_busy)
   );

   // ==========================================================================
   // Drive and pin logic.
   // Off-going outputs drop at the edge; on-going ones wait for their
   // counter. The pin levels are registered so the gate drivers never see
   // a combinational glitch.
   always_comb
   begin
      next_drv_a = drv_a;
      next_drv_b = drv_b;
      if (!unit_enable || (unit_enable && !en_prev))
      begin
         // Drives start cleared at enable and stay cleared while off. [R04]
         next_drv_a = 1'b0;
         next_drv_b = 1'b0;
      end
      else
      begin
         if (in_rise)
         begin
            next_drv_b = 1'b0; // [R11]
         end
         if (in_fall)
         begin
            next_drv_a = 1'b0; // [R12]
         end
         if (rise_fire)
         begin
            next_drv_a = 1'b1; // [R11] [R14]
         end
         if (fall_fire)
         begin
            next_drv_b = 1'b1; // [R12] [R14]
         end
      end
      // Polarity set gives an active-high pin; overrides bypass it. [R07] [R08]
      if (ovr[`CWU_OVR_EN])
      begin
         next_pin_a = ovr[`CWU_OVR_LA];
         next_pin_b = ovr[`CWU_OVR_LB];
      end
      else
      begin
         next_pin_a = ctrl0[`CWU_C0_POLA] ? next_drv_a : !next_drv_a;
         next_pin_b = ctrl0[`CWU_C0_POLB] ? next_drv_b : !next_drv_b;
      end
      // A pin is driven only with both its enable and the unit enable. [R05] [R06]
      next_oe_a = unit_enable && ctrl0[`CWU_C0_OEA];
      next_oe_b = unit_enable && ctrl0[`CWU_C0_OEB];
      if (!next_oe_a)
      begin
         next_pin_a = 1'b0; // [R06]
      end
      if (!next_oe_b)
      begin
         next_pin_b = 1'b0; // [R06]
      end
   end

   // Register the synchroniser, edge history, drives and pins.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_meta <= 1'b0;
         in_sync <= 1'b0;
         in_prev <= 1'b0;
         osc_prev <= 1'b0;
         en_prev <= 1'b0;
         drv_a <= 1'b0;
         drv_b <= 1'b0;
         drive_out_a <= 1'b0;
         drive_out_b <= 1'b0;
         drive_out_a_oe <= 1'b0;
         drive_out_b_oe <= 1'b0;
      end
      else
      begin
         in_meta <= sel_in;
         in_sync <= in_meta;
         in_prev <= in_sync;
         osc_prev <= internal_fast_oscillator;
         en_prev <= unit_enable;
         drv_a <= next_drv_a;
         drv_b <= next_drv_b;
         drive_out_a <= next_pin_a;
         drive_out_b <= next_pin_b;
         drive_out_a_oe <= next_oe_a;
         drive_out_b_oe <= next_oe_b;
      end
   end

endmodule

`default_nettype wire

// ### verification/cwu_gate_model.sv
// Gate driver model that sits on the two drive pins of the wave unit.
`default_nettype none

module cwu_gate_model
(
   input wire logic pin_a,
   input wire logic oe_a,
   input wire logic pin_b,
   input wire logic oe_b,
   output logic gate_a,
   output logic gate_b
);
   timeunit 1ns;
   timeprecision 1ps;

   // A released pin is pulled down, so the power switch is held off.
   assign gate_a = oe_a ? pin_a : 1'b0;
   assign gate_b = oe_b ? pin_b : 1'b0;
endmodule

`default_nettype wire

// ### verification/cwu_properties.sv
// Concurrent checks on the pins of the complementary wave unit.
`default_nettype none

module cwu_checker
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic internal_fast_oscillator,
   input wire logic comparator_out_synced,
   input wire logic pwm_one_output,
   input wire logic pwm_two_output,
   input wire logic pwm_three_output,
   input wire logic pwm_four_output,
   input wire logic numeric_osc_output,
   input wire logic logic_cell_output,
   input wire logic drive_out_a,
   input wire logic drive_out_a_oe,
   input wire logic drive_out_b,
   input wire logic drive_out_b_oe
);
   // Shadow copies of control, select and override, rebuilt from bus writes.
   logic [7:0] c0, next_c0, wa, next_wa;
   logic [2:0] sel, next_sel, ov, next_ov, age, next_age;
   logic wp, next_wp;
   logic [7:0] srcv;
   logic src, aa, ab, ok;

   // ==========================================================
   // Helper logic
   // The age counter hides the few cycles in which a fresh write is
   // still on its way to the pins; checks wait until it settles.
   always_comb
   begin
      next_wp = hsel && hready && htrans[1] && hwrite;
      next_wa = haddr[7:0];
      next_c0 = c0;
      next_sel = sel;
      next_ov = ov;
      next_age = (age == 3'h7) ? age : age + 3'h1;
      if (wp)
      begin
         if (wa == 8'h00) next_c0 = hwdata[7:0] & 8'hf9;
         if (wa == 8'h04) next_sel = hwdata[2:0];
         if (wa == 8'h10) next_ov = hwdata[2:0];
         next_age = 3'h0;
      end
   end

   // Registers of the helper logic, cleared with the unit.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         c0 <= 8'h00;
         sel <= 3'h0;
         ov <= 3'h0;
         age <= 3'h0;
         wp <= 1'b0;
         wa <= 8'h00;
      end
      else
      begin
         c0 <= next_c0;
         sel <= next_sel;
         ov <= next_ov;
         age <= next_age;
         wp <= next_wp;
         wa <= next_wa;
      end
   end

   // Selected source and the active state of each pin after polarity.
   assign srcv = {1'b0, logic_cell_output, numeric_osc_output, pwm_four_output,
      pwm_three_output, pwm_two_output, pwm_one_output, comparator_out_synced};
   assign src = srcv[sel];
   assign aa = drive_out_a_oe && (c0[3] ? drive_out_a : !drive_out_a);
   assign ab = drive_out_b_oe && (c0[4] ? drive_out_b : !drive_out_b);
   assign ok = (age >= 3'h4) && !ov[0];

   // ==========================================================
   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   pin_quiet_a_a: assert property (!drive_out_a_oe |-> !drive_out_a)
      else $error("pin a level high while released");
   pin_quiet_b_a: assert property (!drive_out_b_oe |-> !drive_out_b)
      else $error("pin b level high while released");
   off_no_oe_a: assert property (!c0[7] && !$past(c0[7]) && !$past(c0[7], 2)
      |-> !drive_out_a_oe && !drive_out_b_oe) else $error("pin enabled while unit off");
   oe_a_gate_a: assert property (!c0[5] && !$past(c0[5]) && !$past(c0[5], 2)
      |-> !drive_out_a_oe) else $error("pin a enabled without its enable bit");
   no_overlap_a: assert property (ok |-> !(aa && ab))
      else $error("both outputs active together");
   enable_clear_a: assert property ($rose(c0[7]) && !ov[0] |-> ##[0:2] (!aa && !ab))
      else $error("outputs not cleared at enable");
   override_lvl_a: assert property ((age >= 3'h4) && ov[0]
      |-> (!drive_out_a_oe || drive_out_a == ov[1]) && (!drive_out_b_oe || drive_out_b == ov[2]))
      else $error("override level not on pins");
   a_on_cause_a: assert property (ok && $rose(aa) |-> $past(src, 3))
      else $error("output a turned on without high input");
   b_on_cause_a: assert property (ok && $rose(ab) |-> !$past(src, 3))
      else $error("output b turned on without low input");
   b_off_rise_a: assert property (ok && c0[7] && $rose(src) |-> ##3 !ab)
      else $error("output b not off three cycles after input rise");
   a_off_fall_a: assert property (ok && c0[7] && $fell(src) |-> ##3 !aa)
      else $error("output a not off three cycles after input fall");
endmodule

bind cwu_top cwu_checker i_cwu_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .internal_fast_oscillator(internal_fast_oscillator),
   .comparator_out_synced(comparator_out_synced), .pwm_one_output(pwm_one_output),
   .pwm_two_output(pwm_two_output), .pwm_three_output(pwm_three_output),
   .pwm_four_output(pwm_four_output), .numeric_osc_output(numeric_osc_output),
   .logic_cell_output(logic_cell_output), .drive_out_a(drive_out_a),
   .drive_out_a_oe(drive_out_a_oe), .drive_out_b(drive_out_b), .drive_out_b_oe(drive_out_b_oe));

`default_nettype wire

// ### verification/complementary_deadband_generator_bench.sv
// Self-checking bench of the complementary wave unit.
`default_nettype none

module complementary_deadband_generator_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [6:0] src = 7'h0;
   logic osc = 1'b0;
   logic osc_run = 1'b0;
   logic hreadyout, hresp, pa, pa_oe, pb, pb_oe, ga, gb;
   logic [31:0] hrdata;
   logic rd_ph = 1'b0;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];

   always #2.5 hclk = ~hclk;

   cwu_top i_cwu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .internal_fast_oscillator(osc),
      .comparator_out_synced(src[0]), .pwm_one_output(src[1]), .pwm_two_output(src[2]),
      .pwm_three_output(src[3]), .pwm_four_output(src[4]), .numeric_osc_output(src[5]),
      .logic_cell_output(src[6]), .drive_out_a(pa), .drive_out_a_oe(pa_oe),
      .drive_out_b(pb), .drive_out_b_oe(pb_oe));
   cwu_gate_model i_cwu_gate_model (.pin_a(pa), .oe_a(pa_oe), .pin_b(pb), .oe_b(pb_oe),
      .gate_a(ga), .gate_b(gb));

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic conclude();
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One single AHB-Lite transfer; each phase is held until hready is seen.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   // The expectation is queued first; the monitor pairs it with the data.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask

   // Applies one edge on the first pwm source and follows both gates edge by edge.
   task automatic edge_run(input logic lvl, input int n);
      int k;
      @(posedge hclk);
      src[1] <= lvl;
      for (k = 1; k <= n + 5; k++)
      begin
         @(posedge hclk);
         #1;
         chk(lvl ? "gate a on" : "gate b on", 32'(k >= n + 3), 32'(lvl ? ga : gb));
         if (k >= 3)
            chk(lvl ? "gate b off" : "gate a off", 32'h0, 32'(lvl ? gb : ga));
      end
   endtask

   // ==========================================================
   // Monitor, oscillator and watchdog
   // Read data stand in the cycle after the address phase is taken.
   always @(posedge hclk)
   begin
      if (rd_ph)
         chk("read data", exp_q.pop_front(), hrdata & msk_q.pop_front());
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
   end

   // A slow oscillator, about one 16.7 MHz period per twelve cycles.
   always @(posedge hclk)
      if (osc_run && cyc % 6 == 0)
         osc <= ~osc;

   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         conclude();
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      int i;
      static int rv[4] = '{0, 1, 5, 63};
      logic [7:0] sv;
      void'($urandom(30));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("pins after reset", 32'h0, 32'({pa, pa_oe, pb, pb_oe, hresp}));
      for (i = 0; i < 6; i++)
         rd(8'(i * 4), 32'h0, 32'hffffffff);
      wr(8'h14, 32'h1f);
      wr(8'h20, 32'h1);
      rd(8'h14, 32'h0, 32'hffffffff);
      rd(8'h20, 32'h0, 32'hffffffff);
      wr(8'h00, 32'h07);
      rd(8'h00, 32'h1, 32'hffffffff);
      wr(8'h08, 32'hff);
      rd(8'h08, 32'h3f, 32'hffffffff);
      for (i = 0; i < 8; i++)
      begin
         src <= 7'($urandom());
         wr(8'h04, 32'(i));
         repeat (4) @(posedge hclk);
         sv = {1'b0, src};
         rd(8'h04, 32'(i), 32'hffffffff);
         rd(8'h14, 32'(sv[i]) << 2, 32'h4);
      end
      src <= 7'($urandom()) & 7'h7d;
      wr(8'h04, 32'h1);
      wr(8'h00, 32'hf8);
      for (i = 0; i < 4; i++)
      begin
         wr(8'h08, 32'(rv[i]));
         wr(8'h0c, 32'(rv[3 - i]));
         edge_run(1'b1, rv[i]);
         edge_run(1'b0, rv[3 - i]);
      end
      wr(8'h08, 32'ha);
      src[1] <= 1'b1;
      repeat (5) @(posedge hclk);
      src[1] <= 1'b0;
      repeat (20)
      begin
         @(posedge hclk) #1;
         chk("short pulse a", 32'h0, 32'(ga));
      end
      wr(8'h00, 32'he0);
      repeat (4) @(posedge hclk);
      chk("inverted pins", 32'h2, 32'({pa, pb}));
      wr(8'h10, 32'h5);
      repeat (4) @(posedge hclk);
      chk("override pins", 32'h1, 32'({pa, pb}));
      wr(8'h10, 32'h0);
      wr(8'h00, 32'hc8);
      repeat (4) @(posedge hclk);
      chk("pin enables", 32'h1, 32'({pa_oe, pa, pb_oe}));
      wr(8'h00, 32'h78);
      repeat (4) @(posedge hclk);
      chk("disabled pins", 32'h0, 32'({pa_oe, pb_oe, pa, pb}));
      wr(8'h08, 32'h3);
      wr(8'h00, 32'hf9);
      repeat (4) @(posedge hclk);
      src[1] <= 1'b1;
      repeat (30) @(posedge hclk);
      chk("held oscillator a", 32'h0, 32'(ga));
      rd(8'h14, 32'h8, 32'h18);
      osc_run <= 1'b1;
      repeat (60) @(posedge hclk);
      chk("oscillator a", 32'h1, 32'(ga));
      wr(8'h00, 32'h78);
      wr(8'h00, 32'hf8);
      rd(8'h14, 32'h0, 32'h3);
      conclude();
   end
endmodule

`default_nettype wire
